// File: verilog/rsf_pkg.sv
package rsf_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NREG  = 8;
  localparam int IDX_W = 3;
  localparam int DW    = 32;

  // ****************************************
  // Access classes
  // ****************************************
  typedef enum logic [2:0] {
    SCLS_NONE     = 3'h0,
    SCLS_WR_SEC   = 3'h1,
    SCLS_ATTR_WR  = 3'h2,
    SCLS_ATTR_ERR = 3'h3,
    SCLS_ATTR_SIL = 3'h4,
    SCLS_FREE     = 3'h5,
    SCLS_SEC_ONLY = 3'h6,
    SCLS_NS_ONLY  = 3'h7
  } rsf_sclass_e;

  typedef enum logic [2:0] {
    PCLS_NONE     = 3'h0,
    PCLS_WR_PRIV  = 3'h1,
    PCLS_PRIV     = 3'h2,
    PCLS_ATTR_ERR = 3'h3,
    PCLS_ATTR_SIL = 3'h4,
    PCLS_FREE     = 3'h5
  } rsf_pclass_e;

  // ****************************************
  // Register table: class, reset value, writable bits
  // ****************************************
  localparam rsf_sclass_e SCLASS [NREG] = '{
    SCLS_WR_SEC, SCLS_ATTR_WR, SCLS_ATTR_ERR, SCLS_ATTR_SIL,
    SCLS_FREE, SCLS_SEC_ONLY, SCLS_NS_ONLY, SCLS_FREE};
  localparam rsf_pclass_e PCLASS [NREG] = '{
    PCLS_FREE, PCLS_FREE, PCLS_FREE, PCLS_FREE,
    PCLS_WR_PRIV, PCLS_PRIV, PCLS_ATTR_ERR, PCLS_ATTR_SIL};
  localparam logic [DW-1:0] RST_VAL [NREG] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam logic [DW-1:0] WR_MASK [NREG] = '{
    32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
    32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic             valid;
    logic             write;
    logic             master_secure;
    logic             addr_secure;
    logic             priv;
    logic [IDX_W-1:0] idx;
    logic [DW-1:0]    wdata;
  } rsf_req_s;

  typedef struct packed {
    logic          valid;
    logic          sec_err;
    logic [DW-1:0] rdata;
  } rsf_rsp_s;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] idx;
    logic             write;
    logic             secure;
    logic             priv;
  } rsf_errlog_s;

endpackage

// File: verilog/rsf_decide.sv
module rsf_decide (
  input  wire rsf_pkg::rsf_sclass_e sclass,
  input  wire rsf_pkg::rsf_pclass_e pclass,
  input  wire logic                 attr_secure,
  input  wire logic                 attr_priv,
  input  wire logic                 acc_secure,
  input  wire logic                 acc_priv,
  input  wire logic                 is_write,
  output logic                      allow,
  output logic                      err
);

  logic s_wr_ok;
  logic s_rd_ok;
  logic s_err_cls;
  logic p_wr_ok;
  logic p_rd_ok;
  logic p_err_cls;
  logic s_ok;
  logic p_ok;

  // ****************************************
  // Security dimension
  // ****************************************
  always_comb begin
    s_wr_ok   = 1'b1;
    s_rd_ok   = 1'b1;
    s_err_cls = 1'b0;
    case (sclass)
      rsf_pkg::SCLS_WR_SEC: begin
        s_wr_ok = acc_secure;
      end
      rsf_pkg::SCLS_ATTR_WR: begin
        s_wr_ok = (acc_secure == attr_secure);
      end
      rsf_pkg::SCLS_ATTR_ERR: begin
        s_wr_ok   = (acc_secure == attr_secure);
        s_rd_ok   = (acc_secure == attr_secure);
        s_err_cls = 1'b1;
      end
      rsf_pkg::SCLS_ATTR_SIL: begin
        s_wr_ok = (acc_secure == attr_secure);
        s_rd_ok = (acc_secure == attr_secure);
      end
      rsf_pkg::SCLS_SEC_ONLY: begin
        s_wr_ok   = acc_secure;
        s_rd_ok   = acc_secure;
        s_err_cls = 1'b1;
      end
      rsf_pkg::SCLS_NS_ONLY: begin
        s_wr_ok   = !acc_secure;
        s_rd_ok   = !acc_secure;
        s_err_cls = 1'b1;
      end
      default: begin
        s_wr_ok = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Privilege dimension
  // ****************************************
  always_comb begin
    p_wr_ok   = 1'b1;
    p_rd_ok   = 1'b1;
    p_err_cls = 1'b0;
    case (pclass)
      rsf_pkg::PCLS_WR_PRIV: begin
        p_wr_ok = acc_priv;
      end
      rsf_pkg::PCLS_PRIV: begin
        p_wr_ok   = acc_priv;
        p_rd_ok   = acc_priv;
        p_err_cls = 1'b1;
      end
      rsf_pkg::PCLS_ATTR_ERR: begin
        p_wr_ok   = acc_priv || !attr_priv;
        p_rd_ok   = acc_priv || !attr_priv;
        p_err_cls = 1'b1;
      end
      rsf_pkg::PCLS_ATTR_SIL: begin
        p_wr_ok = acc_priv || !attr_priv;
        p_rd_ok = acc_priv || !attr_priv;
      end
      default: begin
        p_wr_ok = 1'b1;
      end
    endcase
  end

  assign s_ok  = is_write ? s_wr_ok : s_rd_ok;
  assign p_ok  = is_write ? p_wr_ok : p_rd_ok;
  assign allow = s_ok && p_ok;
  assign err   = (!s_ok && s_err_cls) || (!p_ok && p_err_cls);

endmodule

// File: verilog/rsf_filter.sv
module rsf_filter (
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset_n,
  input  wire rsf_pkg::rsf_req_s                     req,
  input  wire logic [rsf_pkg::NREG-1:0]              attr_secure,
  input  wire logic [rsf_pkg::NREG-1:0]              attr_priv,
  output rsf_pkg::rsf_rsp_s                          rsp,
  output logic [rsf_pkg::NREG*rsf_pkg::DW-1:0]       reg_q_flat,
  output rsf_pkg::rsf_errlog_s                       err_log,
  output logic [7:0]                                 err_count
);

  // ****************************************
  // Local types and signals
  // ****************************************
  typedef logic [rsf_pkg::IDX_W-1:0] rsf_idx_t;

  logic                     acc_secure;
  logic [rsf_pkg::NREG-1:0] allow_vec;
  logic [rsf_pkg::NREG-1:0] err_vec;
  logic                     allow;
  logic                     err;
  logic                     wr_take;
  logic                     rd_take;
  logic                     err_take;
  logic [rsf_pkg::NREG-1:0] wr_sel;
  logic [rsf_pkg::DW-1:0]   rd_word;
  logic [rsf_pkg::DW-1:0]   rd_nxt;
  logic [rsf_pkg::DW-1:0]   regs_r [rsf_pkg::NREG];
  logic                     rsp_valid_r;
  logic                     rsp_err_r;
  logic [rsf_pkg::DW-1:0]   rsp_data_r;
  rsf_pkg::rsf_errlog_s     log_r;
  rsf_pkg::rsf_errlog_s     log_nxt;
  logic [7:0]               cnt_r;
  logic [7:0]               cnt_nxt;

  // ****************************************
  // Access security
  // ****************************************
  // Non-secure masters never present a secure address, so the AND only narrows
  assign acc_secure = req.master_secure && req.addr_secure;

  // ****************************************
  // Per-register decision and register bank
  // ****************************************
  // Each register is judged in parallel and the index picks one verdict,
  // so the class tables stay constant per slice and fold away
  genvar gi;
  generate
    for (gi = 0; gi < rsf_pkg::NREG; gi++) begin : g_reg
      rsf_decide u_decide (
        .sclass      (rsf_pkg::SCLASS[gi]),
        .pclass      (rsf_pkg::PCLASS[gi]),
        .attr_secure (attr_secure[gi]),
        .attr_priv   (attr_priv[gi]),
        .acc_secure  (acc_secure),
        .acc_priv    (req.priv),
        .is_write    (req.write),
        .allow       (allow_vec[gi]),
        .err         (err_vec[gi])
      );

      assign wr_sel[gi] = wr_take && (req.idx == rsf_idx_t'(gi));

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          regs_r[gi] <= rsf_pkg::RST_VAL[gi];
        end else if (wr_sel[gi]) begin
          // Only the writable bits take the new value
          regs_r[gi] <= (regs_r[gi] & ~rsf_pkg::WR_MASK[gi])
                      | (req.wdata & rsf_pkg::WR_MASK[gi]);
        end
      end

      assign reg_q_flat[gi*rsf_pkg::DW +: rsf_pkg::DW] = regs_r[gi];
    end
  endgenerate

  // ****************************************
  // Transfer qualification
  // ****************************************
  assign allow    = allow_vec[req.idx];
  assign err      = err_vec[req.idx];
  assign wr_take  = req.valid && req.write && allow;
  assign rd_take  = req.valid && !req.write && allow;
  assign err_take = req.valid && err;

  // ****************************************
  // Read path
  // ****************************************
  assign rd_word = regs_r[req.idx];

  // Blocked reads and every write answer with zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (rd_take) begin
      rd_nxt = rd_word;
    end
  end

  // ****************************************
  // Response: every transfer completes one cycle later
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= req.valid;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_err_r <= 1'b0;
    end else begin
      rsp_err_r <= err_take;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_data_r <= 32'h0000_0000;
    end else begin
      rsp_data_r <= rd_nxt;
    end
  end

  assign rsp = '{valid: rsp_valid_r, sec_err: rsp_err_r, rdata: rsp_data_r};

  // ****************************************
  // Error record: last offending access
  // ****************************************
  always_comb begin
    log_nxt = log_r;
    if (err_take) begin
      log_nxt.valid  = 1'b1;
      log_nxt.idx    = req.idx;
      log_nxt.write  = req.write;
      log_nxt.secure = acc_secure;
      log_nxt.priv   = req.priv;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      log_r <= '0;
    end else begin
      log_r <= log_nxt;
    end
  end

  // ****************************************
  // Error count
  // ****************************************
  // Saturates so that a storm of errors never wraps back to a small count
  always_comb begin
    cnt_nxt = cnt_r;
    if (err_take && (cnt_r != 8'hff)) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign err_log   = log_r;
  assign err_count = cnt_r;

endmodule

// File: testbench/rsf_checker.sv
// ****************************************
// Access filter checker
// ****************************************
module rsf_checker (
  input wire logic                                  ref_clk,
  input wire logic                                  reset_n,
  input wire rsf_pkg::rsf_req_s                     req,
  input wire logic [rsf_pkg::NREG-1:0]              attr_secure,
  input wire logic [rsf_pkg::NREG-1:0]              attr_priv,
  input wire rsf_pkg::rsf_rsp_s                     rsp,
  input wire logic [rsf_pkg::NREG*rsf_pkg::DW-1:0]  reg_q_flat,
  input wire rsf_pkg::rsf_errlog_s                  err_log,
  input wire logic [7:0]                            err_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic s;
  logic a;
  assign s = req.master_secure & req.addr_secure;
  assign a = req.valid;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_rsp_follows: assert property (a |=> rsp.valid)
    else $error("missing response");
  a_rsp_only: assert property (!a |=> !rsp.valid)
    else $error("response without request");
  a_attr_err: assert property (a && req.idx == 3'h2 && s != attr_secure[2]
    |=> rsp.sec_err) else $error("mismatch error missing");
  a_sec_only: assert property (a && req.idx == 3'h5 && !s
    |=> rsp.sec_err && rsp.rdata == 32'h0) else $error("secure-only not blocked");
  a_priv_only: assert property (a && req.idx == 3'h5 && !req.priv
    |=> rsp.sec_err && rsp.rdata == 32'h0) else $error("privileged-only not blocked");
  a_ns_only: assert property (a && req.idx == 3'h6
    && (s || !req.priv && attr_priv[6]) |=> rsp.sec_err)
    else $error("non-secure-only not blocked");
  a_silent_cls: assert property (a && req.idx inside {0, 1, 3, 4, 7}
    |=> !rsp.sec_err) else $error("error on silent class");
  a_keep_block: assert property (a && req.write && req.idx == 3'h5 && !s
    |=> $stable(reg_q_flat[191:160])) else $error("blocked write landed");
  a_free_write: assert property (a && req.write && req.idx == 3'h7
    && (req.priv || !attr_priv[7]) |=> reg_q_flat[255:224] == $past(req.wdata))
    else $error("allowed write lost");
  a_err_record: assert property (rsp.sec_err
    |-> err_log.valid && err_log.idx == $past(req.idx)) else $error("error record wrong");
  cover property (rsp.sec_err);
  cover property (a && req.idx == 3'h5 && !req.priv);
  cover property (a && req.write && req.idx == 3'h2);
  cover property (a && !req.write ##1 rsp.rdata != 32'h0);
endmodule

bind rsf_filter rsf_checker i_rsf_checker (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
  .attr_secure(attr_secure), .attr_priv(attr_priv), .rsp(rsp), .reg_q_flat(reg_q_flat),
  .err_log(err_log), .err_count(err_count));

// File: testbench/rsf_master.sv
module rsf_master (
  input wire logic          ref_clk,
  output rsf_pkg::rsf_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bus master model
  // ****************************************
  initial req = '0;
  task automatic issue(input logic w, m, a, p, input logic [2:0] i, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, w, m, a & m, p, i, d};
  endtask
  // Released lines show the inverse of the last value
  task automatic idle();
    @(posedge ref_clk);
    req <= {1'b0, ~req[38:0]};
  endtask
endmodule

// File: testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bench
  // ****************************************
  logic                 ref_clk;
  logic                 reset_n;
  logic [7:0]           attr_secure;
  logic [7:0]           attr_priv;
  rsf_pkg::rsf_req_s    req;
  rsf_pkg::rsf_rsp_s    rsp;
  logic [255:0]         reg_q_flat;
  rsf_pkg::rsf_errlog_s err_log;
  logic [7:0]           err_count;
  rsf_pkg::rsf_rsp_s    q[$];
  rsf_pkg::rsf_errlog_s lg = '0;
  logic [255:0]         sh = '0;
  logic [1:0]           v;
  logic [31:0]          x;
  int                   bad_count = 0;
  int                   compares = 0;
  int                   ec = 0;

  rsf_master i_rsf_master (.ref_clk(ref_clk), .req(req));
  rsf_filter i_rsf_filter (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
    .attr_secure(attr_secure), .attr_priv(attr_priv), .rsp(rsp), .reg_q_flat(reg_q_flat),
    .err_log(err_log), .err_count(err_count));

  // Returns blocked and error flags
  function automatic logic [1:0] judge(input rsf_pkg::rsf_req_s r, input logic [7:0] sa, pa);
    logic s;
    logic m;
    logic w;
    logic n;
    logic [1:0] o;
    s = r.master_secure & r.addr_secure;
    m = (s == sa[r.idx]);
    w = r.write;
    n = !r.priv;
    case (rsf_pkg::SCLASS[r.idx])
      rsf_pkg::SCLS_WR_SEC:   o = {w & !s, 1'b0};
      rsf_pkg::SCLS_ATTR_WR:  o = {w & !m, 1'b0};
      rsf_pkg::SCLS_ATTR_ERR: o = {!m, !m};
      rsf_pkg::SCLS_ATTR_SIL: o = {!m, 1'b0};
      rsf_pkg::SCLS_SEC_ONLY: o = {!s, !s};
      rsf_pkg::SCLS_NS_ONLY:  o = {s, s};
      default:                o = 2'h0;
    endcase
    case (rsf_pkg::PCLASS[r.idx])
      rsf_pkg::PCLS_WR_PRIV:  o[1] |= w & n;
      rsf_pkg::PCLS_PRIV:     o |= {n, n};
      rsf_pkg::PCLS_ATTR_ERR: o |= {2{n & pa[r.idx]}};
      rsf_pkg::PCLS_ATTR_SIL: o[1] |= n & pa[r.idx];
      default:                o = o;
    endcase
    return o;
  endfunction

  task automatic check(input logic [255:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Scoreboard: response one cycle after each valid request, blocked or not
  always @(posedge ref_clk) begin
    if (rsp.valid || q.size() > 0) begin
      check(256'(rsp), (q.size() > 0) ? 256'(q.pop_front()) : 256'h0);
      check(reg_q_flat, sh);
      check(256'(err_log), 256'(lg));
    end
    if (req.valid) begin
      v = judge(req, attr_secure, attr_priv);
      ec += v[0];
      q.push_back('{1'b1, v[0], (req.write | v[1]) ? 32'h0 : sh[req.idx*32 +: 32]});
      if (req.write & !v[1]) sh[req.idx*32 +: 32] = req.wdata;
      if (v[0]) begin
        lg = '{1'b1, req.idx, req.write, req.master_secure & req.addr_secure, req.priv};
      end
    end
  end

  initial begin
    repeat (8000) @(posedge ref_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    attr_secure = 8'h00;
    attr_priv = 8'h00;
    x = $urandom(32'ha2c902e4);
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 256; k++) begin
      i_rsf_master.issue(k[3], k[4], k[5], k[6], k[2:0], $urandom);
      attr_secure <= {8{k[7]}};
      attr_priv <= {8{k[7]}};
    end
    repeat (2000) begin
      x = $urandom;
      if (x[9:8] == 2'h0) i_rsf_master.idle();
      else i_rsf_master.issue(x[0], x[1], x[2], x[3], x[6:4], $urandom);
      if (x[12:10] == 3'h0) begin
        attr_secure <= x[20:13];
        attr_priv <= x[28:21];
      end
    end
    i_rsf_master.idle();
    repeat (3) @(posedge ref_clk);
    check(256'(err_count), 256'((ec > 255) ? 8'hff : ec[7:0]));
    check(256'(q.size()), 256'h0);
    complete_run();
  end
endmodule
